// [rtl/mmcsm_params.svh]
// Constants of the master-side coherency state machine: offsets, fields, codes.
// Assumes an APB slave with 32-bit data and one aligned word per register.
`ifndef MMCSM_PARAMS_SVH
`define MMCSM_PARAMS_SVH
// Register byte offsets
`define MMCSM_CTRL_OFS     12'h000
`define MMCSM_REQ_OFS      12'h004
`define MMCSM_STATUS_OFS   12'h008
`define MMCSM_IRQ_STS_OFS  12'h00c
`define MMCSM_IRQ_MASK_OFS 12'h010
// Request field positions
`define MMCSM_REQ_OP_LSB   0
`define MMCSM_REQ_MODE_LSB 4
`define MMCSM_REQ_CS_LSB   8
`define MMCSM_REQ_COH_BIT  12
// Control bits
`define MMCSM_CTRL_L3_BIT  0
`define MMCSM_CTRL_LOW_BIT 1
// Interrupt status bits
`define MMCSM_IRQ_DONE     0
`define MMCSM_IRQ_PARADOX  1
`define MMCSM_IRQ_ALIGN    2
`define MMCSM_IRQ_RETRY    3
`define MMCSM_IRQ_W        4
`endif

// [rtl/mmcsm_pkg.sv]
// Types of the master-side coherency state machine.
// Assumes the constants header sits beside this file.
`include "mmcsm_params.svh"
package mmcsm_pkg;
  // Block coherency state
  typedef enum logic [1:0] {
    MMCSM_I = 2'h0,
    MMCSM_S = 2'h1,
    MMCSM_E = 2'h2,
    MMCSM_M = 2'h3
  } mmcsm_mesi_e;
  // Processor request
  typedef enum logic [3:0] {
    MMCSM_PLAIN_LOAD      = 4'h0,
    MMCSM_LOAD_RESERVE    = 4'h1,
    MMCSM_DATA_TOUCH      = 4'h2,
    MMCSM_PLAIN_STORE     = 4'h3,
    MMCSM_STORE_COND      = 4'h4,
    MMCSM_STORE_TOUCH     = 4'h5,
    MMCSM_DEALLOCATE      = 4'h6,
    MMCSM_BLOCK_FLUSH     = 4'h7,
    MMCSM_BLOCK_INVALIDATE = 4'h8,
    MMCSM_BLOCK_STORE     = 4'h9,
    MMCSM_BLOCK_ZERO      = 4'ha
  } mmcsm_op_e;
  // Page access attributes, folded into one mode
  typedef enum logic [1:0] {
    MMCSM_WRITE_BACK    = 2'h0,
    MMCSM_WRITE_THROUGH = 2'h1,
    MMCSM_NON_CACHEABLE = 2'h2,
    MMCSM_MODE_RSVD     = 2'h3
  } mmcsm_mode_e;
  // Coherent bus operation
  typedef enum logic [3:0] {
    MMCSM_BUS_NONE    = 4'h0,
    MMCSM_BUS_RD_BURST = 4'h1,
    MMCSM_BUS_RD_SINGLE = 4'h2,
    MMCSM_BUS_RD_INTENT = 4'h3,
    MMCSM_BUS_CLAIM   = 4'h4,
    MMCSM_BUS_WR_FLUSH = 4'h5,
    MMCSM_BUS_WR_KILL = 4'h6,
    MMCSM_BUS_WR_CLEAN = 4'h7,
    MMCSM_BUS_FLUSH   = 4'h8,
    MMCSM_BUS_KILL    = 4'h9,
    MMCSM_BUS_CLEAN   = 4'ha,
    MMCSM_BUS_RESERVE = 4'hb
  } mmcsm_busop_e;
  // Combined snoop reply
  typedef enum logic [1:0] {
    MMCSM_RESP_NULL   = 2'h0,
    MMCSM_RESP_SHARED = 2'h1,
    MMCSM_RESP_MOD    = 2'h2,
    MMCSM_RESP_RETRY  = 2'h3
  } mmcsm_resp_e;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    MMCSM_IDLE  = 3'h1,
    MMCSM_ISSUE = 3'h2,
    MMCSM_WAIT  = 3'h4
  } mmcsm_fsm_e;
  // Decision for one request
  typedef struct packed {
    mmcsm_busop_e busop;
    mmcsm_mesi_e  fin;
    logic         settle;
    logic         paradox;
    logic         align;
  } mmcsm_dec_s;
  // Whole state of the top module
  typedef struct packed {
    mmcsm_fsm_e   fsm;
    logic         l3_en;
    logic         lowest;
    mmcsm_op_e    op;
    mmcsm_mode_e  mode;
    mmcsm_mesi_e  cs;
    logic         coh;
    mmcsm_mesi_e  fin;
    mmcsm_busop_e busop;
    logic         settle;
    mmcsm_resp_e  last_resp;
    logic [`MMCSM_IRQ_W-1:0] irq_sts;
    logic [`MMCSM_IRQ_W-1:0] irq_mask;
    logic [2:0]   vld_sync;
    logic [1:0]   resp_s1;
    logic [1:0]   resp_s2;
    logic         bus_req;
    logic [31:0]  prdata;
    logic         pslverr;
  } mmcsm_state_s;
endpackage

// [rtl/mmcsm_top.sv]
// Master-side MESI state machine for one addressed data cache block, APB programmed.
// Assumes a bus agent outside that issues the coherent operation and returns the
// combined snoop reply as asynchronous level pins.
//
// Notes on behaviour
// - arrow entries move state, others keep.
// - undefined combinations flagged as coherency paradox.
// - combined reply merges all; blank is don't-care.
// - fill from invalid: shared reply S, null E.
// - cacheable load hit: no bus op, reserve if L3.
// - load miss burst reads; modified reply ends shared.
// - non-cacheable load single-beat; touch does nothing.
// - write-back store: E/M silent, S claim, I intent.
// - store-touch uses coherence bit for S and I.
// - write-through store write-flush, state kept; no conditional.
// - non-cacheable stores write-flush; store-touch does nothing.
// - deallocate: M write-kill, all end invalid.
// - block flush: M write-kill, else flush; invalid.
// - block invalidate: kill op, any state invalid.
// - block store on M: write-clean, E lowest else S.
// - block store S/E clean settles if L3, else kept; I cleans.
// - block zero write-back to M; else alignment error.
`timescale 1ns/1ns
`default_nettype none
`include "mmcsm_params.svh"
module mmcsm_top (
  input  wire logic        pclk,           // Bus clock, 125 MHz
  input  wire logic        presetn,        // Asynchronous reset
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             bus_req,        // One-cycle issue strobe
  output logic [3:0]       bus_op,         // Operation being issued
  input  wire logic        bus_resp_valid, // Combined reply present (level)
  input  wire logic [1:0]  combined_snoop_reply,
  output logic             irq             // Level interrupt
);
  mmcsm_pkg::mmcsm_state_s q;              // Registered state
  mmcsm_pkg::mmcsm_state_s d;              // Next state
  mmcsm_pkg::mmcsm_dec_s   dec;            // Decision for the request on pwdata
  logic                    wr_acc;         // Write in access phase
  logic                    rd_setup;       // Read in setup phase
  logic                    req_start;      // Accepted request write
  logic                    resp_ev;        // Reply just arrived
  logic                    mapped;         // Address hits a register
  mmcsm_pkg::mmcsm_mesi_e  settled;        // Final state chosen by the reply

  // Decide bus operation and final state for one request
  function automatic mmcsm_pkg::mmcsm_dec_s decide(
    input mmcsm_pkg::mmcsm_op_e   op,
    input mmcsm_pkg::mmcsm_mode_e mode,
    input mmcsm_pkg::mmcsm_mesi_e cs,
    input logic                   coh,
    input logic                   l3_en,
    input logic                   lowest);
    mmcsm_pkg::mmcsm_dec_s r;
    logic ca;
    logic wb;
    r = '{busop: mmcsm_pkg::MMCSM_BUS_NONE, fin: cs, settle: 1'b0, paradox: 1'b0, align: 1'b0};
    ca = (mode == mmcsm_pkg::MMCSM_WRITE_BACK) || (mode == mmcsm_pkg::MMCSM_WRITE_THROUGH);
    wb = (mode == mmcsm_pkg::MMCSM_WRITE_BACK);
    case (op)
      mmcsm_pkg::MMCSM_PLAIN_LOAD, mmcsm_pkg::MMCSM_LOAD_RESERVE, mmcsm_pkg::MMCSM_DATA_TOUCH: begin
        if (ca && cs != mmcsm_pkg::MMCSM_I) begin
          // Hit keeps state; reservation only seen below when L3 exists
          if (op == mmcsm_pkg::MMCSM_LOAD_RESERVE && l3_en)
            r.busop = mmcsm_pkg::MMCSM_BUS_RESERVE;
        end else if (ca) begin
          r.busop  = mmcsm_pkg::MMCSM_BUS_RD_BURST;
          r.settle = 1'b1;
        end else if (op != mmcsm_pkg::MMCSM_DATA_TOUCH) begin
          r.busop = mmcsm_pkg::MMCSM_BUS_RD_SINGLE;
        end
      end
      mmcsm_pkg::MMCSM_PLAIN_STORE, mmcsm_pkg::MMCSM_STORE_COND: begin
        if (wb) begin
          r.fin = mmcsm_pkg::MMCSM_M;
          if (cs == mmcsm_pkg::MMCSM_S)
            r.busop = mmcsm_pkg::MMCSM_BUS_CLAIM;
          else if (cs == mmcsm_pkg::MMCSM_I)
            r.busop = mmcsm_pkg::MMCSM_BUS_RD_INTENT;
        end else if (ca && op == mmcsm_pkg::MMCSM_STORE_COND) begin
          r.paradox = 1'b1;
        end else begin
          r.busop = mmcsm_pkg::MMCSM_BUS_WR_FLUSH;
        end
      end
      mmcsm_pkg::MMCSM_STORE_TOUCH: begin
        // Only this request looks at the coherence bit; other modes are no-ops
        if (wb && cs == mmcsm_pkg::MMCSM_S && coh) begin
          r.busop = mmcsm_pkg::MMCSM_BUS_CLAIM;
          r.fin   = mmcsm_pkg::MMCSM_M;
        end else if (wb && cs == mmcsm_pkg::MMCSM_I && coh) begin
          r.busop = mmcsm_pkg::MMCSM_BUS_RD_INTENT;
          r.fin   = mmcsm_pkg::MMCSM_M;
        end else if (wb && cs == mmcsm_pkg::MMCSM_I) begin
          r.busop  = mmcsm_pkg::MMCSM_BUS_RD_BURST;
          r.settle = 1'b1;
        end
      end
      mmcsm_pkg::MMCSM_DEALLOCATE, mmcsm_pkg::MMCSM_BLOCK_FLUSH, mmcsm_pkg::MMCSM_BLOCK_INVALIDATE: begin
        r.fin = mmcsm_pkg::MMCSM_I;
        if (!ca)
          r.paradox = 1'b1;
        else if (op == mmcsm_pkg::MMCSM_BLOCK_INVALIDATE)
          r.busop = mmcsm_pkg::MMCSM_BUS_KILL;
        else if (cs == mmcsm_pkg::MMCSM_M)
          r.busop = mmcsm_pkg::MMCSM_BUS_WR_KILL;
        else if (op == mmcsm_pkg::MMCSM_BLOCK_FLUSH)
          r.busop = mmcsm_pkg::MMCSM_BUS_FLUSH;
      end
      mmcsm_pkg::MMCSM_BLOCK_STORE: begin
        if (!ca) begin
          r.paradox = 1'b1;
        end else if (cs == mmcsm_pkg::MMCSM_M) begin
          r.busop = mmcsm_pkg::MMCSM_BUS_WR_CLEAN;
          r.fin   = lowest ? mmcsm_pkg::MMCSM_E : mmcsm_pkg::MMCSM_S;
        end else if (cs == mmcsm_pkg::MMCSM_I) begin
          r.busop = mmcsm_pkg::MMCSM_BUS_CLEAN;
        end else if (l3_en) begin
          // Without L3 the clean is skipped and S or E is kept
          r.busop  = mmcsm_pkg::MMCSM_BUS_CLEAN;
          r.settle = 1'b1;
        end
      end
      mmcsm_pkg::MMCSM_BLOCK_ZERO: begin
        if (wb) begin
          r.fin = mmcsm_pkg::MMCSM_M;
          if (cs == mmcsm_pkg::MMCSM_I || cs == mmcsm_pkg::MMCSM_S)
            r.busop = mmcsm_pkg::MMCSM_BUS_CLAIM;
        end else if (ca || mode == mmcsm_pkg::MMCSM_NON_CACHEABLE) begin
          r.align = 1'b1;
        end
      end
      default: r.paradox = 1'b1;
    endcase
    // Reserved mode has no defined row at all
    if (mode == mmcsm_pkg::MMCSM_MODE_RSVD) begin
      r.paradox = 1'b1;
      r.align   = 1'b0;
    end
    if (r.paradox || r.align) begin
      r.busop  = mmcsm_pkg::MMCSM_BUS_NONE;
      r.fin    = cs;
      r.settle = 1'b0;
    end
    return r;
  endfunction

  // Bus phase decode
  assign wr_acc    = psel && penable && pwrite;
  assign rd_setup  = psel && !penable && !pwrite;
  assign mapped    = (paddr == `MMCSM_CTRL_OFS) || (paddr == `MMCSM_REQ_OFS) || (paddr == `MMCSM_STATUS_OFS)
                  || (paddr == `MMCSM_IRQ_STS_OFS) || (paddr == `MMCSM_IRQ_MASK_OFS);
  // A new request is only taken while idle; later writes are dropped
  assign req_start = wr_acc && (paddr == `MMCSM_REQ_OFS) && (q.fsm == mmcsm_pkg::MMCSM_IDLE);
  // Edge of the synchronised valid; first sync stage is read by nothing else
  assign resp_ev   = q.vld_sync[1] && !q.vld_sync[2];
  assign dec = decide(mmcsm_pkg::mmcsm_op_e'(pwdata[`MMCSM_REQ_OP_LSB +: 4]),
                      mmcsm_pkg::mmcsm_mode_e'(pwdata[`MMCSM_REQ_MODE_LSB +: 2]),
                      mmcsm_pkg::mmcsm_mesi_e'(pwdata[`MMCSM_REQ_CS_LSB +: 2]),
                      pwdata[`MMCSM_REQ_COH_BIT], q.l3_en, q.lowest);

  // Reply chooses the final state: shared or modified give S, null gives E
  always_comb begin
    if (!q.settle)
      settled = q.fin;
    else if (mmcsm_pkg::mmcsm_resp_e'(q.resp_s2) == mmcsm_pkg::MMCSM_RESP_NULL)
      settled = mmcsm_pkg::MMCSM_E;
    else
      settled = mmcsm_pkg::MMCSM_S;
  end

  // Next state of everything
  always_comb begin
    logic [`MMCSM_IRQ_W-1:0] ev;
    ev = '0;
    d  = q;
    d.bus_req  = 1'b0;
    d.vld_sync = {q.vld_sync[1:0], bus_resp_valid};
    d.resp_s1  = combined_snoop_reply;
    d.resp_s2  = q.resp_s1;
    // Register writes
    if (wr_acc && paddr == `MMCSM_CTRL_OFS) begin
      d.l3_en  = pwdata[`MMCSM_CTRL_L3_BIT];
      d.lowest = pwdata[`MMCSM_CTRL_LOW_BIT];
    end
    if (wr_acc && paddr == `MMCSM_IRQ_MASK_OFS)
      d.irq_mask = pwdata[`MMCSM_IRQ_W-1:0];
    // Sequencer
    case (q.fsm)
      mmcsm_pkg::MMCSM_IDLE: begin
        if (req_start) begin
          d.op     = mmcsm_pkg::mmcsm_op_e'(pwdata[`MMCSM_REQ_OP_LSB +: 4]);
          d.mode   = mmcsm_pkg::mmcsm_mode_e'(pwdata[`MMCSM_REQ_MODE_LSB +: 2]);
          d.cs     = mmcsm_pkg::mmcsm_mesi_e'(pwdata[`MMCSM_REQ_CS_LSB +: 2]);
          d.coh    = pwdata[`MMCSM_REQ_COH_BIT];
          d.fin    = dec.fin;
          d.busop  = dec.busop;
          d.settle = dec.settle;
          ev[`MMCSM_IRQ_PARADOX] = dec.paradox;
          ev[`MMCSM_IRQ_ALIGN]   = dec.align;
          if (dec.busop != mmcsm_pkg::MMCSM_BUS_NONE)
            d.fsm = mmcsm_pkg::MMCSM_ISSUE;
          else
            ev[`MMCSM_IRQ_DONE] = 1'b1;
        end
      end
      mmcsm_pkg::MMCSM_ISSUE: begin
        d.bus_req = 1'b1;
        d.fsm     = mmcsm_pkg::MMCSM_WAIT;
      end
      mmcsm_pkg::MMCSM_WAIT: begin
        if (resp_ev) begin
          d.last_resp = mmcsm_pkg::mmcsm_resp_e'(q.resp_s2);
          if (mmcsm_pkg::mmcsm_resp_e'(q.resp_s2) == mmcsm_pkg::MMCSM_RESP_RETRY) begin
            // Same operation goes out again, state untouched
            d.fsm = mmcsm_pkg::MMCSM_ISSUE;
            ev[`MMCSM_IRQ_RETRY] = 1'b1;
          end else begin
            d.fin = settled;
            d.fsm = mmcsm_pkg::MMCSM_IDLE;
            ev[`MMCSM_IRQ_DONE] = 1'b1;
          end
        end
      end
      default: d.fsm = mmcsm_pkg::MMCSM_IDLE;
    endcase
    // Write one to clear; a new event in the same cycle wins
    if (wr_acc && paddr == `MMCSM_IRQ_STS_OFS)
      d.irq_sts = q.irq_sts & ~pwdata[`MMCSM_IRQ_W-1:0];
    d.irq_sts = d.irq_sts | ev;
    // Read data captured in setup so it is a flop during access
    if (rd_setup) begin
      d.prdata = '0;
      case (paddr)
        `MMCSM_CTRL_OFS:     d.prdata = {30'h0, q.lowest, q.l3_en};
        `MMCSM_REQ_OFS:      d.prdata = {19'h0, q.coh, 2'h0, q.cs, 2'h0, q.mode, q.op};
        `MMCSM_STATUS_OFS:   d.prdata = {10'h0, q.last_resp, q.busop, 6'h0, q.fin,
                                         7'h0, (q.fsm != mmcsm_pkg::MMCSM_IDLE)};
        `MMCSM_IRQ_STS_OFS:  d.prdata = {28'h0, q.irq_sts};
        `MMCSM_IRQ_MASK_OFS: d.prdata = {28'h0, q.irq_mask};
        default:             d.prdata = '0;
      endcase
    end
    if (psel && !penable)
      d.pslverr = !mapped;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{fsm: mmcsm_pkg::MMCSM_IDLE, op: mmcsm_pkg::MMCSM_PLAIN_LOAD,
             mode: mmcsm_pkg::MMCSM_WRITE_BACK, cs: mmcsm_pkg::MMCSM_I, fin: mmcsm_pkg::MMCSM_I,
             busop: mmcsm_pkg::MMCSM_BUS_NONE, last_resp: mmcsm_pkg::MMCSM_RESP_NULL, default: '0};
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign prdata  = q.prdata;
  assign pslverr = q.pslverr && psel && penable;
  assign pready  = 1'b1; // Every access completes with no wait state
  assign bus_req = q.bus_req;
  assign bus_op  = q.busop;
  assign irq     = |(q.irq_sts & q.irq_mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Reply arrival in the wait state
  sequence s_reply(logic [1:0] r);
    (q.fsm == mmcsm_pkg::MMCSM_WAIT) && resp_ev && q.resp_s2 == r;
  endsequence

  a_retry_reissue: assert property (s_reply(2'h3) |=> q.fsm == mmcsm_pkg::MMCSM_ISSUE
                     && $stable(q.fin) ##1 bus_req) else $error("retry did not reissue");
  a_fill_shared: assert property (s_reply(2'h1) && q.settle |=> q.fin == mmcsm_pkg::MMCSM_S)
                   else $error("shared reply did not settle S");
  a_fill_null: assert property (s_reply(2'h0) && q.settle |=> q.fin == mmcsm_pkg::MMCSM_E)
                 else $error("null reply did not settle E");
  a_mod_interv: assert property (s_reply(2'h2) && q.settle |=> q.fin == mmcsm_pkg::MMCSM_S)
                  else $error("modified reply did not settle S");
  a_paradox_flag: assert property (req_start && dec.paradox |=> q.irq_sts[`MMCSM_IRQ_PARADOX]
                    && q.fsm == mmcsm_pkg::MMCSM_IDLE) else $error("paradox not flagged");
  a_zero_align: assert property (req_start && pwdata[3:0] == 4'ha && pwdata[5:4] == 2'h1
                  |=> q.irq_sts[`MMCSM_IRQ_ALIGN]) else $error("zero on write-through no alignment");
  a_inval_kill: assert property (req_start && pwdata[3:0] == 4'h8 && pwdata[5:4] == 2'h0
                  |=> bus_op == mmcsm_pkg::MMCSM_BUS_KILL && q.fin == mmcsm_pkg::MMCSM_I ##1 bus_req)
                  else $error("invalidate did not issue kill");
  a_load_hit: assert property (req_start && pwdata[3:0] == 4'h0 && pwdata[5:4] == 2'h0
                && pwdata[9:8] != 2'h0 |=> q.fsm == mmcsm_pkg::MMCSM_IDLE && q.fin == q.cs)
                else $error("load hit changed state");
  a_store_miss: assert property (req_start && pwdata[3:0] == 4'h3 && pwdata[5:4] == 2'h0
                  && pwdata[9:8] == 2'h0 |=> bus_op == mmcsm_pkg::MMCSM_BUS_RD_INTENT
                  && q.fin == mmcsm_pkg::MMCSM_M) else $error("store miss not intent read");
  a_nc_load: assert property (req_start && pwdata[3:0] == 4'h0 && pwdata[5:4] == 2'h2
               |=> bus_op == mmcsm_pkg::MMCSM_BUS_RD_SINGLE) else $error("no single read");
endmodule
`default_nettype wire

// [verification/mmcsm_snoop_agent.sv]
// Behavioural far side of the coherent bus: snooping caches plus memory controller.
// Assumes bus_req is a one-cycle strobe from the block and answers with a held reply level.
`timescale 1ns/1ns
`default_nettype none
module mmcsm_snoop_agent (
  input  wire logic       pclk,                 // Bus clock
  input  wire logic       presetn,              // Asynchronous reset
  input  wire logic       bus_req,              // Issue strobe from the block
  input  wire logic [3:0] bus_op,               // Operation being issued
  input  wire logic [1:0] cfg_reply,            // Merged reply chosen by the bench
  input  wire logic       retry_once,           // First answer of a request is a retry
  output logic            bus_resp_valid,       // Reply present
  output logic [1:0]      combined_snoop_reply, // Merged reply of all snoopers
  output logic [7:0]      n_ops,                // Count of issued operations
  output logic [3:0]      last_op               // Last issued operation
);
  logic       pend_q;   // A request waits for its answer
  logic [3:0] wait_q;   // Cycles waited before answering
  logic [2:0] hold_q;   // Cycles the reply has stood
  logic       used_q;   // Retry already given for this request
  // Odd requests are answered slowly, even ones promptly, so both paths are seen
  wire  [3:0] dly = n_ops[0] ? 4'h6 : 4'h1;
  // Answer sequencer; the reply line shows the inverse of its last value once released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q               <= 1'b0;
      wait_q               <= 4'h0;
      hold_q               <= 3'h0;
      used_q               <= 1'b0;
      bus_resp_valid       <= 1'b0;
      combined_snoop_reply <= 2'h0;
      n_ops                <= 8'h00;
      last_op              <= 4'h0;
    end else begin
      if (!retry_once) begin
        used_q <= 1'b0;
      end
      if (bus_resp_valid) begin
        // Hold long enough for the block's synchroniser, then release
        hold_q <= hold_q + 3'h1;
        if (hold_q == 3'h3) begin
          bus_resp_valid       <= 1'b0;
          combined_snoop_reply <= ~combined_snoop_reply;
        end
      end else if (pend_q) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == dly) begin
          bus_resp_valid <= 1'b1;
          // One merged answer stands for every participant
          combined_snoop_reply <= (retry_once && !used_q) ? 2'h3 : cfg_reply;
          used_q <= retry_once;
          pend_q <= 1'b0;
          wait_q <= 4'h0;
          hold_q <= 3'h0;
        end
      end
      // A strobe is latched even while an older reply still stands
      if (bus_req) begin
        pend_q  <= 1'b1;
        n_ops   <= n_ops + 8'h01;
        last_op <= bus_op;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench: APB tasks drive requests, the snoop agent answers them.
// Assumes the block answers APB with no wait states and flags status through IRQ_STS.
`timescale 1ns/1ns
`default_nettype none
`include "mmcsm_params.svh"
module tb;
  logic        pclk;                 // 125 MHz clock
  logic        presetn;              // Active-low reset
  logic        psel;                 // APB select
  logic        penable;              // APB access phase
  logic        pwrite;               // APB direction
  logic [11:0] paddr;                // APB address
  logic [31:0] pwdata;               // APB write data
  logic [31:0] prdata;               // APB read data
  logic        pready;               // APB ready
  logic        pslverr;              // APB error
  logic        bus_req;              // Issue strobe
  logic [3:0]  bus_op;               // Issued operation
  logic        bus_resp_valid;       // Reply present
  logic [1:0]  combined_snoop_reply; // Merged reply
  logic        irq;                  // Interrupt level
  logic [1:0]  cfg_reply;            // Reply the agent will give
  logic        retry_once;           // Agent retries first
  logic [7:0]  n_ops;                // Agent's operation count
  logic [3:0]  last_op;              // Agent's last operation
  int          n_fail;
  int          n_compared;
  logic [31:0] r;                    // Scratch read data
  logic        e;                    // Scratch error flag

  mmcsm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_req(bus_req), .bus_op(bus_op), .bus_resp_valid(bus_resp_valid),
    .combined_snoop_reply(combined_snoop_reply), .irq(irq));
  mmcsm_snoop_agent i_agent (.pclk(pclk), .presetn(presetn), .bus_req(bus_req), .bus_op(bus_op),
    .cfg_reply(cfg_reply), .retry_once(retry_once), .bus_resp_valid(bus_resp_valid),
    .combined_snoop_reply(combined_snoop_reply), .n_ops(n_ops), .last_op(last_op));

  // Clock generator
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the answer is taken at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd_q, output logic err);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd_q = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, d, x, y);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic y;
    apb(1'b0, a, 32'h0, d, y);
  endtask

  // One request: program, wait for idle, then compare state, bus op, traffic and flags
  task automatic run(input logic [3:0] op, input logic [1:0] md, input logic [1:0] cs, input logic coh,
                     input logic [1:0] ctl, input logic [1:0] rp, input logic [3:0] bo,
                     input logic [1:0] fin, input logic [3:0] fl);
    logic [31:0] s;
    logic [7:0]  n0;
    int          k;
    cfg_reply  <= rp;
    retry_once <= fl[3];
    wr(`MMCSM_CTRL_OFS, {30'h0, ctl});
    n0 = n_ops;
    wr(`MMCSM_REQ_OFS, {19'h0, coh, 2'h0, cs, 2'h0, md, op});
    k = 0;
    do begin
      rd(`MMCSM_STATUS_OFS, s);
      k++;
    end while (s[0] !== 1'b0 && k < 40);
    if (k >= 40) begin
      n_fail++;
      report_and_stop();
    end
    chk({30'h0, s[9:8]}, {30'h0, fin});
    chk({28'h0, s[19:16]}, {28'h0, bo});
    chk({24'h0, n_ops - n0}, (bo == 4'h0) ? 32'h0 : (fl[3] ? 32'h2 : 32'h1));
    if (bo != 4'h0) begin
      chk({28'h0, last_op}, {28'h0, bo});
    end
    rd(`MMCSM_IRQ_STS_OFS, s);
    chk({29'h0, s[3:1]}, {29'h0, fl[3:1]});
    if (fl[2:1] == 2'h0) begin
      chk({31'h0, s[0]}, 32'h1);
    end
    wr(`MMCSM_IRQ_STS_OFS, 32'hf);
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (50000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cfg_reply = 2'h0;
    retry_once = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped address
    rd(`MMCSM_CTRL_OFS, r);
    chk(r, 32'h0);
    rd(`MMCSM_IRQ_MASK_OFS, r);
    chk(r, 32'h0);
    apb(1'b0, 12'hff0, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // op md cs coh ctl reply busop fin flags
    run(4'h0, 2'h0, 2'h3, 1'b0, 2'h0, 2'h0, 4'h0, 2'h3, 4'h0);
    run(4'h1, 2'h0, 2'h1, 1'b0, 2'h1, 2'h0, 4'hb, 2'h1, 4'h0);
    run(4'h1, 2'h0, 2'h2, 1'b0, 2'h0, 2'h0, 4'h0, 2'h2, 4'h0);
    run(4'h2, 2'h0, 2'h0, 1'b0, 2'h0, 2'h1, 4'h1, 2'h1, 4'h0);
    run(4'h0, 2'h0, 2'h0, 1'b0, 2'h0, 2'h0, 4'h1, 2'h2, 4'h0);
    run(4'h1, 2'h0, 2'h0, 1'b0, 2'h0, 2'h2, 4'h1, 2'h1, 4'h0);
    run(4'h0, 2'h2, 2'h0, 1'b0, 2'h0, 2'h0, 4'h2, 2'h0, 4'h0);
    run(4'h2, 2'h2, 2'h1, 1'b0, 2'h0, 2'h0, 4'h0, 2'h1, 4'h0);
    run(4'h3, 2'h0, 2'h2, 1'b0, 2'h0, 2'h0, 4'h0, 2'h3, 4'h0);
    run(4'h4, 2'h0, 2'h1, 1'b0, 2'h0, 2'h0, 4'h4, 2'h3, 4'h0);
    run(4'h3, 2'h0, 2'h0, 1'b0, 2'h0, 2'h0, 4'h3, 2'h3, 4'h0);
    run(4'h5, 2'h0, 2'h0, 1'b0, 2'h0, 2'h0, 4'h1, 2'h2, 4'h0);
    run(4'h5, 2'h0, 2'h0, 1'b1, 2'h0, 2'h0, 4'h3, 2'h3, 4'h0);
    run(4'h5, 2'h0, 2'h1, 1'b0, 2'h0, 2'h0, 4'h0, 2'h1, 4'h0);
    run(4'h3, 2'h1, 2'h1, 1'b0, 2'h0, 2'h0, 4'h5, 2'h1, 4'h0);
    run(4'h4, 2'h1, 2'h1, 1'b0, 2'h0, 2'h0, 4'h0, 2'h1, 4'h2);
    run(4'h4, 2'h2, 2'h0, 1'b0, 2'h0, 2'h0, 4'h5, 2'h0, 4'h0);
    run(4'h5, 2'h1, 2'h2, 1'b0, 2'h0, 2'h0, 4'h0, 2'h2, 4'h0);
    run(4'h6, 2'h0, 2'h3, 1'b0, 2'h0, 2'h0, 4'h6, 2'h0, 4'h0);
    run(4'h6, 2'h0, 2'h1, 1'b0, 2'h0, 2'h0, 4'h0, 2'h0, 4'h0);
    run(4'h7, 2'h0, 2'h3, 1'b0, 2'h0, 2'h0, 4'h6, 2'h0, 4'h0);
    run(4'h7, 2'h0, 2'h2, 1'b0, 2'h0, 2'h0, 4'h8, 2'h0, 4'h0);
    run(4'h8, 2'h0, 2'h3, 1'b0, 2'h0, 2'h0, 4'h9, 2'h0, 4'h0);
    run(4'h9, 2'h0, 2'h3, 1'b0, 2'h2, 2'h0, 4'h7, 2'h2, 4'h0);
    run(4'h9, 2'h0, 2'h3, 1'b0, 2'h0, 2'h0, 4'h7, 2'h1, 4'h0);
    run(4'h9, 2'h0, 2'h1, 1'b0, 2'h1, 2'h0, 4'ha, 2'h2, 4'h0);
    run(4'h9, 2'h0, 2'h0, 1'b0, 2'h0, 2'h0, 4'ha, 2'h0, 4'h0);
    run(4'ha, 2'h0, 2'h2, 1'b0, 2'h0, 2'h0, 4'h0, 2'h3, 4'h0);
    run(4'ha, 2'h0, 2'h0, 1'b0, 2'h0, 2'h0, 4'h4, 2'h3, 4'h0);
    run(4'ha, 2'h1, 2'h1, 1'b0, 2'h0, 2'h0, 4'h0, 2'h1, 4'h4);
    run(4'h0, 2'h3, 2'h1, 1'b0, 2'h0, 2'h0, 4'h0, 2'h1, 4'h2);
    run(4'h3, 2'h0, 2'h1, 1'b0, 2'h0, 2'h0, 4'h4, 2'h3, 4'h8);
    // Interrupt raised when unmasked, dropped on clear, silent when masked
    wr(`MMCSM_IRQ_MASK_OFS, 32'h1);
    wr(`MMCSM_REQ_OFS, 32'h300);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(`MMCSM_IRQ_STS_OFS, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`MMCSM_IRQ_MASK_OFS, 32'h0);
    wr(`MMCSM_REQ_OFS, 32'h300);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
